// File: ccpg_clock_config.sv
// file: top of the codec clock, pll and shared pin configuration block
// Operation
// - rate field bits 3:1 selects filter coefficients, 110/111 reserved, default 48k
// - filter and level timings assume a 256 times sample-rate master clock
// - pll power bit 5 of power register: 0 off, 1 on, reset off
// - integer ratio at bits 3:0 resets to 8; software uses 6 to 12
// - prescale bit 4 halves the reference before the pll input
// - 24-bit fraction split across three registers, high, mid, low parts
// - pll output divided by fixed 4 then selectable post divide by 2
// - pin function select codes and polarity inversion of the pin output
// - pin general functions only in two-wire mode; three-wire uses chip select
// - pin clock output divided by 1, 2, 3 or 4, reset divide 1
// - pll drives the internal master clock or a clock on the pin
// - clock source bit: 0 external master clock, 1 pll output, reset 1
// - core scaler divides by 1,1.5,2,3,4,6,8,12; reset code 010
`timescale 1ns/1ps
module ccpg_clock_config
    import ccpg_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // register write port (decoded control word)
    input wire logic reg_wr_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [8:0] reg_wdata_i,
    // register readback port
    input wire logic [6:0] reg_raddr_i,
    output logic [8:0] reg_rdata_o,
    // analog pll core
    input wire logic pll_edge_i,
    input wire logic pll_lock_i,
    output ccpg_pll_cfg_t pll_cfg_o,
    output logic pll_ref_tick_o,
    // status sources and mode pin
    input wire logic ctrl_mode_i,
    input wire logic jack_detect_i,
    input wire logic temp_ok_i,
    input wire logic auto_mute_i,
    // filters and core clock
    output logic [2:0] sample_rate_sel_o,
    output logic core_clk_o,
    output logic core_clk_tick_o,
    // shared select pin
    input wire logic shared_select_pin_i,
    output logic shared_select_pin_o,
    output logic shared_select_pin_oe_o,
    output logic chip_sel_n_o
);

    // =========================================================
    // register file
    logic [8:0] power_mgmt_one_reg, power_mgmt_one_next;
    logic [8:0] clock_gen_control_reg, clock_gen_control_next;
    logic [8:0] extra_control_reg, extra_control_next;
    logic [8:0] shared_pin_control_reg, shared_pin_control_next;
    logic [8:0] pll_integer_ratio_reg, pll_integer_ratio_next;
    logic [8:0] pll_fraction_high_reg, pll_fraction_high_next;
    logic [8:0] pll_fraction_mid_reg, pll_fraction_mid_next;
    logic [8:0] pll_fraction_low_reg, pll_fraction_low_next;
    logic [8:0] rdata_reg, rdata_next;

    // a write to the reset address returns every register to its default
    always_comb begin
        power_mgmt_one_next = power_mgmt_one_reg;
        clock_gen_control_next = clock_gen_control_reg;
        extra_control_next = extra_control_reg;
        shared_pin_control_next = shared_pin_control_reg;
        pll_integer_ratio_next = pll_integer_ratio_reg;
        pll_fraction_high_next = pll_fraction_high_reg;
        pll_fraction_mid_next = pll_fraction_mid_reg;
        pll_fraction_low_next = pll_fraction_low_reg;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_SOFT_RESET: begin
                    power_mgmt_one_next = RST_POWER_MGMT_ONE;
                    clock_gen_control_next = RST_CLOCK_GEN_CONTROL;
                    extra_control_next = RST_EXTRA_CONTROL;
                    shared_pin_control_next = RST_SHARED_PIN_CONTROL;
                    pll_integer_ratio_next = RST_PLL_INTEGER_RATIO;
                    pll_fraction_high_next = RST_PLL_FRACTION_HIGH;
                    pll_fraction_mid_next = RST_PLL_FRACTION_MID;
                    pll_fraction_low_next = RST_PLL_FRACTION_LOW;
                end
                ADDR_POWER_MGMT_ONE: power_mgmt_one_next = reg_wdata_i;
                ADDR_CLOCK_GEN_CONTROL: clock_gen_control_next = reg_wdata_i;
                ADDR_EXTRA_CONTROL: extra_control_next = reg_wdata_i;
                ADDR_SHARED_PIN_CONTROL: shared_pin_control_next = reg_wdata_i;
                ADDR_PLL_INTEGER_RATIO: pll_integer_ratio_next = reg_wdata_i;
                ADDR_PLL_FRACTION_HIGH: pll_fraction_high_next = reg_wdata_i;
                ADDR_PLL_FRACTION_MID: pll_fraction_mid_next = reg_wdata_i;
                ADDR_PLL_FRACTION_LOW: pll_fraction_low_next = reg_wdata_i;
                default: ; // other addresses belong to other blocks
            endcase
        end
        // readback; unmapped addresses read as zero
        unique case (reg_raddr_i)
            ADDR_POWER_MGMT_ONE: rdata_next = power_mgmt_one_reg;
            ADDR_CLOCK_GEN_CONTROL: rdata_next = clock_gen_control_reg;
            ADDR_EXTRA_CONTROL: rdata_next = extra_control_reg;
            ADDR_SHARED_PIN_CONTROL: rdata_next = shared_pin_control_reg;
            ADDR_PLL_INTEGER_RATIO: rdata_next = pll_integer_ratio_reg;
            ADDR_PLL_FRACTION_HIGH: rdata_next = pll_fraction_high_reg;
            ADDR_PLL_FRACTION_MID: rdata_next = pll_fraction_mid_reg;
            ADDR_PLL_FRACTION_LOW: rdata_next = pll_fraction_low_reg;
            default: rdata_next = 9'h000;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            power_mgmt_one_reg <= RST_POWER_MGMT_ONE;
            clock_gen_control_reg <= RST_CLOCK_GEN_CONTROL;
            extra_control_reg <= RST_EXTRA_CONTROL;
            shared_pin_control_reg <= RST_SHARED_PIN_CONTROL;
            pll_integer_ratio_reg <= RST_PLL_INTEGER_RATIO;
            pll_fraction_high_reg <= RST_PLL_FRACTION_HIGH;
            pll_fraction_mid_reg <= RST_PLL_FRACTION_MID;
            pll_fraction_low_reg <= RST_PLL_FRACTION_LOW;
            rdata_reg <= 9'h000;
        end else if (ce_i) begin
            power_mgmt_one_reg <= power_mgmt_one_next;
            clock_gen_control_reg <= clock_gen_control_next;
            extra_control_reg <= extra_control_next;
            shared_pin_control_reg <= shared_pin_control_next;
            pll_integer_ratio_reg <= pll_integer_ratio_next;
            pll_fraction_high_reg <= pll_fraction_high_next;
            pll_fraction_mid_reg <= pll_fraction_mid_next;
            pll_fraction_low_reg <= pll_fraction_low_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // =========================================================
    // field extraction
    logic pll_on;
    logic pll_halve;
    logic pll_post_div2;
    logic core_src_pll;
    logic [2:0] core_scaler;
    logic [2:0] rate_field;
    logic [1:0] pin_clk_div;

    assign pll_on = power_mgmt_one_reg[PLL_POWER_ON_BIT];
    assign pll_halve = pll_integer_ratio_reg[PLL_INPUT_HALVE_BIT];
    assign pll_post_div2 = clock_gen_control_reg[PLL_POST_DIV_BIT];
    assign core_src_pll = clock_gen_control_reg[CORE_CLK_SRC_BIT];
    assign core_scaler = clock_gen_control_reg[CORE_CLK_SCALER_LSB +: 3];
    assign rate_field = extra_control_reg[SAMPLE_RATE_LSB +: 3];
    assign pin_clk_div = shared_pin_control_reg[PIN_CLK_DIV_LSB +: 2];

    // =========================================================
    // pll configuration, filter rate and reference prescaler
    ccpg_pll_cfg_t pll_cfg_reg, pll_cfg_next;
    logic [2:0] rate_reg, rate_next;
    logic ref_phase_reg, ref_phase_next;
    logic ref_tick_reg, ref_tick_next;

    // reserved rate codes keep the last legal coefficient set, so the
    // filters never run on undefined coefficients; the 256fs clock itself
    // is the user's concern
    always_comb begin
        pll_cfg_next.pll_power_on = pll_on;
        pll_cfg_next.pll_input_halve = pll_halve;
        pll_cfg_next.pll_int_ratio = pll_integer_ratio_reg[PLL_INT_RATIO_LSB +: 4];
        pll_cfg_next.pll_frac_ratio = {pll_fraction_high_reg[5:0],
                                       pll_fraction_mid_reg,
                                       pll_fraction_low_reg};
        rate_next = (rate_field <= RATE_LAST_LEGAL) ? rate_field : rate_reg;
        // halving lets only every other reference edge through
        ref_phase_next = pll_halve ? ~ref_phase_reg : 1'b0;
        ref_tick_next = pll_on & (~pll_halve | ref_phase_reg);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pll_cfg_reg <= '0;
            rate_reg <= RATE_DEFAULT;
            ref_phase_reg <= 1'b0;
            ref_tick_reg <= 1'b0;
        end else if (ce_i) begin
            pll_cfg_reg <= pll_cfg_next;
            rate_reg <= rate_next;
            ref_phase_reg <= ref_phase_next;
            ref_tick_reg <= ref_tick_next;
        end
    end

    assign pll_cfg_o = pll_cfg_reg;
    assign sample_rate_sel_o = rate_reg;
    assign pll_ref_tick_o = ref_tick_reg;

    // =========================================================
    // pll output path: fixed divide by 4, optional post divide by 2
    logic pll_out_tick;
    logic [5:0] pll_div2;
    logic pll_edge_gated;

    assign pll_edge_gated = pll_edge_i & pll_on;
    assign pll_div2 = pll_post_div2 ? PLL_FIXED_POST_DIV2 : PLL_FIXED_DIV2;

    ccpg_tick_divider u_pll_post (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(pll_edge_gated),
        .ratio2_i(pll_div2),
        .tick_o(pll_out_tick)
    );

    // =========================================================
    // core clock: source select, then scaler
    logic core_src_tick;
    logic core_tick;

    assign core_src_tick = core_src_pll ? pll_out_tick : 1'b1;

    ccpg_tick_divider u_core_scaler (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(core_src_tick),
        .ratio2_i(SCALER_DIV2[core_scaler]),
        .tick_o(core_tick)
    );

    // =========================================================
    // pin clock divider: code n divides by n+1
    logic pin_tick;
    logic [5:0] pin_div2;

    assign pin_div2 = {3'h0, pin_clk_div, 1'b0} + 6'h02;

    ccpg_tick_divider u_pin_div (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(pll_out_tick),
        .ratio2_i(pin_div2),
        .tick_o(pin_tick)
    );

    // each tick is a half period, so the clock levels toggle on ticks
    logic core_clk_reg, core_clk_next;
    logic core_tick_reg, core_tick_next;
    logic pin_clk_reg, pin_clk_next;

    always_comb begin
        core_clk_next = core_clk_reg ^ core_tick;
        core_tick_next = core_tick;
        pin_clk_next = pin_clk_reg ^ pin_tick;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            core_clk_reg <= 1'b0;
            core_tick_reg <= 1'b0;
            pin_clk_reg <= 1'b0;
        end else if (ce_i) begin
            core_clk_reg <= core_clk_next;
            core_tick_reg <= core_tick_next;
            pin_clk_reg <= pin_clk_next;
        end
    end

    assign core_clk_o = core_clk_reg;
    assign core_clk_tick_o = core_tick_reg;

    // =========================================================
    // shared select pin
    ccpg_status_t status;

    assign status = '{jack_detect: jack_detect_i, temp_ok: temp_ok_i,
                      auto_mute: auto_mute_i, pll_lock: pll_lock_i};

    ccpg_pin_mux u_pin_mux (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .ctrl_mode_i(ctrl_mode_i),
        .func_sel_i(shared_pin_control_reg[PIN_FUNC_LSB +: 3]),
        .invert_i(shared_pin_control_reg[PIN_INVERT_BIT]),
        .status_i(status),
        .pin_clk_i(pin_clk_reg),
        .pin_i(shared_select_pin_i),
        .pin_o(shared_select_pin_o),
        .pin_oe_o(shared_select_pin_oe_o),
        .chip_sel_n_o(chip_sel_n_o)
    );

endmodule

// File: ccpg_clock_config_asserts.sv
// concurrent checks on the top ports of the clock block
`timescale 1ns/1ps
module ccpg_clock_config_asserts
    import ccpg_pkg::*;
(
    // clock, reset, register writes
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [8:0] reg_wdata_i,
    // pll side and clocks
    input wire ccpg_pll_cfg_t pll_cfg_o,
    input wire logic pll_ref_tick_o,
    input wire logic [2:0] sample_rate_sel_o,
    input wire logic core_clk_o,
    input wire logic core_clk_tick_o,
    // shared pin
    input wire logic ctrl_mode_i,
    input wire logic shared_select_pin_i,
    input wire logic shared_select_pin_oe_o,
    input wire logic chip_sel_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // ==========================================================
    // register to pll path: a write lands two edges later
    sequence s_int_wr;
        ce_i && reg_wr_i && reg_addr_i == ADDR_PLL_INTEGER_RATIO ##1 ce_i;
    endsequence
    a_int_ratio_wr: assert property (
        s_int_wr |=> pll_cfg_o.pll_int_ratio == $past(reg_wdata_i[3:0], 2))
        else $error("integer ratio did not follow the write");
    a_rate_legal: assert property (sample_rate_sel_o <= 3'h5)
        else $error("filter rate code outside the legal set");
    // reference gating; two samples of margin cover the register stage
    a_ref_off: assert property ((!pll_cfg_o.pll_power_on)[*2] |-> !pll_ref_tick_o)
        else $error("reference ticks while the pll is off");
    a_ref_halve: assert property (
        (pll_cfg_o.pll_input_halve && ce_i)[*2] ##0 pll_ref_tick_o ##1 pll_cfg_o.pll_input_halve
        |-> !pll_ref_tick_o)
        else $error("halved reference ticked twice in a row");
    a_ref_full: assert property (
        (pll_cfg_o.pll_power_on && !pll_cfg_o.pll_input_halve && ce_i)[*3] |-> pll_ref_tick_o)
        else $error("undivided reference missed a cycle");

    // ==========================================================
    // shared pin direction and chip select
    a_three_wire_oe: assert property (ce_i && ctrl_mode_i |=> !shared_select_pin_oe_o)
        else $error("pin driven in three-wire mode");
    a_three_wire_cs: assert property (
        ce_i && ctrl_mode_i |=> chip_sel_n_o == $past(shared_select_pin_i))
        else $error("chip select does not follow the pin");
    a_drive_not_cs: assert property (shared_select_pin_oe_o |-> chip_sel_n_o)
        else $error("pin driven while acting as chip select");
    a_core_toggle: assert property (
        ce_i |=> $changed(core_clk_o) == core_clk_tick_o)
        else $error("core clock toggle not tied to its tick");
endmodule

// File: ccpg_clock_config_test.sv
// self-checking bench for the clock, pll and shared pin block
`timescale 1ns/1ps
module ccpg_clock_config_test;
    import ccpg_pkg::*;
    logic mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00, reg_raddr_i = 7'h00;
    logic [8:0] reg_wdata_i = 9'h000, reg_rdata_o;
    logic pll_edge_i, pll_lock_i, pll_ref_tick_o, core_clk_o, core_clk_tick_o;
    logic ctrl_mode_i = 1'b0, jack_detect_i = 1'b1, temp_ok_i = 1'b0, auto_mute_i = 1'b1;
    logic [2:0] sample_rate_sel_o;
    logic shared_select_pin_i, shared_select_pin_o, shared_select_pin_oe_o, chip_sel_n_o;
    logic ext_lvl = 1'b1, pin_q = 1'b0;
    logic [2:0] fs[4] = '{3'h1, 3'h2, 3'h3, 3'h5};
    logic [3:0] lv = 4'hd;
    int div2[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
    int miscompares = 0, comparisons = 0, ntick = 0, npin = 0, n0 = 0;
    ccpg_pll_cfg_t pll_cfg_o;

    // the wire carries the block's drive when enabled, else the outside level
    assign shared_select_pin_i = shared_select_pin_oe_o ? shared_select_pin_o : ext_lvl;
    always #50 mclk_i = ~mclk_i;

    ccpg_clock_config dut (.mclk_i, .srst_i, .ce_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
        .reg_raddr_i, .reg_rdata_o, .pll_edge_i, .pll_lock_i, .pll_cfg_o, .pll_ref_tick_o,
        .ctrl_mode_i, .jack_detect_i, .temp_ok_i, .auto_mute_i, .sample_rate_sel_o,
        .core_clk_o, .core_clk_tick_o, .shared_select_pin_i, .shared_select_pin_o,
        .shared_select_pin_oe_o, .chip_sel_n_o);
    ccpg_pll_model pll (.mclk_i, .srst_i, .pll_cfg_i(pll_cfg_o),
        .pll_ref_tick_i(pll_ref_tick_o), .pll_edge_o(pll_edge_i), .pll_lock_o(pll_lock_i));

    // edge counters for rate checks
    always @(posedge mclk_i) begin
        ntick += int'(core_clk_tick_o === 1'b1);
        npin += int'(shared_select_pin_o !== pin_q);
        pin_q = shared_select_pin_o;
    end

    // ==========================================================
    // access tasks
    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int n, input int e);
        chk(30'(n >= e - 1 && n <= e + 1), 30'h1);
    endtask
    task automatic idle(input int n);
        reg_wr_i = 1'b0;
        repeat (n) @(posedge mclk_i) #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge mclk_i) #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        reg_raddr_i = a;
        idle(2);
        chk(30'(reg_rdata_o), 30'(e));
    endtask
    task automatic rate(input logic [8:0] a, input int e);
        wr(7'h06, a);
        idle(4);
        ntick = 0;
        idle(96);
        near(ntick, e);
    endtask
    task automatic defaults();
        rd(7'h01, 9'h000);
        rd(7'h06, 9'h140);
        rd(7'h07, 9'h000);
        rd(7'h08, 9'h000);
        rd(7'h24, 9'h008);
        rd(7'h25, 9'h00c);
        rd(7'h26, 9'h093);
        rd(7'h27, 9'h0e9);
        rd(7'h30, 9'h000);
        chk(pll_cfg_o, 30'h083126e9);
    endtask
    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge mclk_i) #1;
        srst_i = 1'b0;
        defaults();
        wr(7'h25, 9'h021);
        wr(7'h26, 9'h161);
        wr(7'h27, 9'h027);
        wr(7'h24, 9'h017);
        wr(7'h01, 9'h020);
        idle(8);
        chk(pll_cfg_o, 30'h3786c227);
        for (int c = 0; c < 8; c++) begin
            wr(7'h07, 9'(c << 1));
            idle(3);
            chk(30'(sample_rate_sel_o), 30'(c > 5 ? 5 : c));
        end
        rd(7'h07, 9'h00e);
        wr(7'h24, 9'h008);
        for (int c = 0; c < 8; c++) begin
            rate(9'(c << 5), 192 / div2[c]);
        end
        rate(9'h100, 24);
        rate(9'h102, 12);
        for (int d = 0; d < 4; d++) begin
            wr(7'h08, 9'(9'h004 | d << 4));
            idle(4);
            npin = 0;
            idle(96);
            n0 = (d == 0) ? npin : n0;
            near(npin, n0 / (d + 1));
        end
        chk(30'(n0 >= 12), 30'h1);
        for (int i = 0; i < 8; i++) begin
            wr(7'h08, {5'h00, 1'(i / 4), fs[i % 4]});
            idle(3);
            chk(30'({shared_select_pin_oe_o, shared_select_pin_o}),
                30'({1'b1, lv[i % 4] ^ 1'(i / 4)}));
        end
        wr(7'h08, 9'h006);
        idle(3);
        chk(30'({shared_select_pin_oe_o, chip_sel_n_o}), 30'h1);
        wr(7'h08, 9'h000);
        ext_lvl = 1'b0;
        idle(3);
        chk(30'({shared_select_pin_oe_o, chip_sel_n_o}), 30'h0);
        wr(7'h08, 9'h001);
        ctrl_mode_i = 1'b1;
        idle(3);
        chk(30'({shared_select_pin_oe_o, chip_sel_n_o}), 30'h0);
        ctrl_mode_i = 1'b0;
        wr(7'h00, 9'h1ff);
        idle(2);
        defaults();
        ce_i = 1'b0;
        wr(7'h07, 9'h00a);
        idle(2);
        ce_i = 1'b1;
        rd(7'h07, 9'h000);
        summarize();
    end

    // hang guard, about six times the expected run
    initial begin
        #1_000_000;
        miscompares++;
        summarize();
    end
endmodule

bind ccpg_clock_config ccpg_clock_config_asserts u_asserts (.mclk_i, .srst_i, .ce_i,
    .reg_wr_i, .reg_addr_i, .reg_wdata_i, .pll_cfg_o, .pll_ref_tick_o, .sample_rate_sel_o,
    .core_clk_o, .core_clk_tick_o, .ctrl_mode_i, .shared_select_pin_i,
    .shared_select_pin_oe_o, .chip_sel_n_o);

// File: ccpg_pin_mux.sv
// file: shared select pin function multiplexer with polarity and direction control
`timescale 1ns/1ps
module ccpg_pin_mux
    import ccpg_pkg::*;
(
    // clock and control
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // configuration
    input wire logic ctrl_mode_i,
    input wire logic [2:0] func_sel_i,
    input wire logic invert_i,
    // sources
    input wire ccpg_status_t status_i,
    input wire logic pin_clk_i,
    input wire logic pin_i,
    // pin and chip select
    output logic pin_o,
    output logic pin_oe_o,
    output logic chip_sel_n_o
);

    logic pin_reg;
    logic pin_next;
    logic oe_reg;
    logic oe_next;
    logic cs_n_reg;
    logic cs_n_next;
    logic level;

    // =========================================================
    // pick the level; input and reserved codes leave the pin undriven
    always_comb begin
        level = 1'b0;
        oe_next = 1'b0;
        cs_n_next = 1'b1;
        if (ctrl_mode_i) begin
            cs_n_next = pin_i;
        end else begin
            oe_next = 1'b1;
            unique case (ccpg_pin_func_t'(func_sel_i))
                CCPG_PIN_CHIP_SEL: begin
                    oe_next = 1'b0;
                    cs_n_next = pin_i;
                end
                CCPG_PIN_JACK: level = status_i.jack_detect;
                CCPG_PIN_TEMP_OK: level = status_i.temp_ok;
                CCPG_PIN_AUTO_MUTE: level = status_i.auto_mute;
                CCPG_PIN_PLL_CLK: level = pin_clk_i;
                CCPG_PIN_PLL_LOCK: level = status_i.pll_lock;
                CCPG_PIN_RSVD6, CCPG_PIN_RSVD7: oe_next = 1'b0;
            endcase
        end
        pin_next = level ^ invert_i;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
            cs_n_reg <= 1'b1;
        end else if (ce_i) begin
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            cs_n_reg <= cs_n_next;
        end
    end

    assign pin_o = pin_reg;
    assign pin_oe_o = oe_reg;
    assign chip_sel_n_o = cs_n_reg;

endmodule

// File: ccpg_pkg.sv
// package: register map, field positions, reset values and carriers for the clock block
package ccpg_pkg;

    // =========================================================
    // register offsets (7-bit control word address)
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_POWER_MGMT_ONE = 7'h01;
    localparam logic [6:0] ADDR_CLOCK_GEN_CONTROL = 7'h06;
    localparam logic [6:0] ADDR_EXTRA_CONTROL = 7'h07;
    localparam logic [6:0] ADDR_SHARED_PIN_CONTROL = 7'h08;
    localparam logic [6:0] ADDR_PLL_INTEGER_RATIO = 7'h24;
    localparam logic [6:0] ADDR_PLL_FRACTION_HIGH = 7'h25;
    localparam logic [6:0] ADDR_PLL_FRACTION_MID = 7'h26;
    localparam logic [6:0] ADDR_PLL_FRACTION_LOW = 7'h27;

    // =========================================================
    // reset values (9-bit registers)
    localparam logic [8:0] RST_POWER_MGMT_ONE = 9'h000;
    localparam logic [8:0] RST_CLOCK_GEN_CONTROL = 9'h140;
    localparam logic [8:0] RST_EXTRA_CONTROL = 9'h000;
    localparam logic [8:0] RST_SHARED_PIN_CONTROL = 9'h000;
    localparam logic [8:0] RST_PLL_INTEGER_RATIO = 9'h008;
    localparam logic [8:0] RST_PLL_FRACTION_HIGH = 9'h00c;
    localparam logic [8:0] RST_PLL_FRACTION_MID = 9'h093;
    localparam logic [8:0] RST_PLL_FRACTION_LOW = 9'h0e9;

    // =========================================================
    // field positions
    localparam int PLL_POWER_ON_BIT = 5;
    localparam int SAMPLE_RATE_LSB = 1;
    localparam int PLL_POST_DIV_BIT = 1;
    localparam int CORE_CLK_SCALER_LSB = 5;
    localparam int CORE_CLK_SRC_BIT = 8;
    localparam int PIN_FUNC_LSB = 0;
    localparam int PIN_INVERT_BIT = 3;
    localparam int PIN_CLK_DIV_LSB = 4;
    localparam int PLL_INPUT_HALVE_BIT = 4;
    localparam int PLL_INT_RATIO_LSB = 0;

    // =========================================================
    // sample-rate codes; 110 and 111 are reserved
    localparam logic [2:0] RATE_LAST_LEGAL = 3'h5;
    localparam logic [2:0] RATE_DEFAULT = 3'h0;
    localparam int MCLK_PER_FS = 256;

    // =========================================================
    // divider ratios in half-steps (divide by r is written as 2*r)
    localparam logic [5:0] PLL_FIXED_DIV2 = 6'h08;
    localparam logic [5:0] PLL_FIXED_POST_DIV2 = 6'h10;
    localparam logic [5:0] SCALER_DIV2 [8] = '{6'h02, 6'h03, 6'h04, 6'h06,
                                              6'h08, 6'h0c, 6'h10, 6'h18};

    // shared pin functions
    typedef enum logic [2:0] {
        CCPG_PIN_CHIP_SEL = 3'h0,
        CCPG_PIN_JACK = 3'h1,
        CCPG_PIN_TEMP_OK = 3'h2,
        CCPG_PIN_AUTO_MUTE = 3'h3,
        CCPG_PIN_PLL_CLK = 3'h4,
        CCPG_PIN_PLL_LOCK = 3'h5,
        CCPG_PIN_RSVD6 = 3'h6,
        CCPG_PIN_RSVD7 = 3'h7
    } ccpg_pin_func_t;

    // configuration handed to the analog pll core
    typedef struct packed {
        logic pll_power_on;
        logic pll_input_halve;
        logic [3:0] pll_int_ratio;
        logic [23:0] pll_frac_ratio;
    } ccpg_pll_cfg_t;

    // status levels that may be routed to the shared pin
    typedef struct packed {
        logic jack_detect;
        logic temp_ok;
        logic auto_mute;
        logic pll_lock;
    } ccpg_status_t;

endpackage

// File: ccpg_pll_model.sv
// stand-in for the analog pll core: edges follow reference ticks, lock after a delay
`timescale 1ns/1ps
module ccpg_pll_model
    import ccpg_pkg::*;
#(
    parameter int LOCK_TICKS = 16
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // from the block
    input wire ccpg_pll_cfg_t pll_cfg_i,
    input wire logic pll_ref_tick_i,
    // back to the block
    output logic pll_edge_o,
    output logic pll_lock_o
);
    logic [7:0] lock_cnt_reg;

    // ==========================================================
    // powered off means no edges and lock lost at once, as the real core
    always_ff @(posedge mclk_i) begin
        if (srst_i || !pll_cfg_i.pll_power_on) begin
            lock_cnt_reg <= 8'h00;
            pll_edge_o <= 1'b0;
        end else begin
            pll_edge_o <= pll_ref_tick_i;
            if (pll_ref_tick_i && lock_cnt_reg != 8'hff) begin
                lock_cnt_reg <= lock_cnt_reg + 8'h01;
            end
        end
    end
    assign pll_lock_o = (lock_cnt_reg >= 8'(LOCK_TICKS));
endmodule

// File: ccpg_tick_divider.sv
// file: fractional tick divider working in half-steps of the input tick rate
`timescale 1ns/1ps
module ccpg_tick_divider
    import ccpg_pkg::*;
(
    // clock and control
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // tick in, ratio, tick out
    input wire logic tick_i,
    input wire logic [5:0] ratio2_i,
    output logic tick_o
);

    logic [5:0] acc_reg;
    logic [5:0] acc_next;
    logic tick_reg;
    logic tick_next;
    logic [6:0] sum;

    // =========================================================
    // accumulate two half-steps per tick; emit when a whole ratio is reached.
    // half-steps let the 1.5 ratio come out as two ticks per three in
    always_comb begin
        sum = {1'b0, acc_reg} + 7'h02;
        acc_next = acc_reg;
        tick_next = 1'b0;
        if (tick_i) begin
            if (sum >= {1'b0, ratio2_i}) begin
                acc_next = 6'(sum - {1'b0, ratio2_i});
                tick_next = 1'b1;
                // a lowered ratio must not leave the count above it
                if (acc_next >= ratio2_i) begin
                    acc_next = 6'h00;
                end
            end else begin
                acc_next = sum[5:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_reg <= 6'h00;
            tick_reg <= 1'b0;
        end else if (ce_i) begin
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule
